// ### sse_defines.svh
// offsets, field positions, reset values and codes of the subtract/swap/sleep datapath
`ifndef SSE_DEFINES_SVH
`define SSE_DEFINES_SVH

// register byte offsets
`define SSE_OFF_CMD 8'h00
`define SSE_OFF_ACC 8'h04
`define SSE_OFF_STATUS 8'h08
`define SSE_OFF_FADDR 8'h0C
`define SSE_OFF_FDATA 8'h10
`define SSE_OFF_LAST 8'h14

// command word fields
`define SSE_CMD_LIT_LSB 0
`define SSE_CMD_FADDR_LSB 8
`define SSE_CMD_DEST_BIT 15
`define SSE_CMD_OP_LSB 16
`define SSE_CMD_MASK 32'h0007FFFF

// operation codes
`define SSE_OP_NONE 3'h0
`define SSE_OP_LIT 3'h1
`define SSE_OP_FILE 3'h2
`define SSE_OP_BORROW 3'h3
`define SSE_OP_SWAP 3'h4
`define SSE_OP_SLEEP 3'h5

// status register bits
`define SSE_ST_C 0
`define SSE_ST_DC 1
`define SSE_ST_Z 2
`define SSE_ST_PD 3
`define SSE_ST_TO 4
`define SSE_ST_SLEEP 5

// reset values
`define SSE_ACC_RST 8'h00
`define SSE_FADDR_RST 7'h00
`define SSE_CMD_RST 32'h00000000

// bus answers
`define SSE_RESP_OKAY 2'h0
`define SSE_RESP_SLVERR 2'h2

`endif

// ### sse_pkg.sv
// types shared by the subtract/swap/sleep datapath
package sse_pkg;

  // operation selector
  typedef logic [2:0] sse_op_t;

  // core power state
  typedef enum {SSE_RUN, SSE_SLEEP} sse_pwr_t;

  // decoded register index
  typedef enum {SSE_REG_CMD, SSE_REG_ACC, SSE_REG_STATUS, SSE_REG_FADDR,
                SSE_REG_FDATA, SSE_REG_LAST, SSE_REG_NONE} sse_reg_t;

endpackage

// ### sse_alu.sv
// combinational subtract and nibble-exchange unit
`timescale 1ns/10ps
`include "sse_defines.svh"

module sse_alu
  import sse_pkg::*;
(
  // operation and operands
  input wire sse_op_t op,
  input wire logic [7:0] file_val,
  input wire logic [7:0] acc_val,
  input wire logic [7:0] lit_val,
  input wire logic carry_in,
  // result and flags
  output logic [7:0] result,
  output logic result_valid,
  output logic flags_we,
  output logic carry_out,
  output logic dc_out,
  output logic zero_out
);

  logic [7:0] minuend;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] sum5;

  // minuend plus inverted accumulator plus carry-in is a two's complement subtract
  always_comb begin
    minuend = (op == `SSE_OP_LIT) ? lit_val : file_val;
    cin = (op == `SSE_OP_BORROW) ? carry_in : 1'b1;
    sum9 = {1'b0, minuend} + {1'b0, ~acc_val} + {8'h00, cin};
    sum5 = {1'b0, minuend[3:0]} + {1'b0, ~acc_val[3:0]} + {4'h0, cin};
    result = 8'h00;
    result_valid = 1'b0;
    flags_we = 1'b0;
    carry_out = 1'b0;
    dc_out = 1'b0;
    zero_out = 1'b0;
    case (op)
      `SSE_OP_LIT, `SSE_OP_FILE, `SSE_OP_BORROW: begin
        result = sum9[7:0];
        result_valid = 1'b1;
        flags_we = 1'b1;
        carry_out = sum9[8];
        dc_out = sum5[4];
        zero_out = (sum9[7:0] == 8'h00);
      end
      `SSE_OP_SWAP: begin
        result = {file_val[3:0], file_val[7:4]};
        result_valid = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

endmodule

// ### sse_exec.sv
// execution datapath for subtract, nibble exchange and sleep, with AXI4-Lite registers
//
// Summary of operation
// - literal minus accumulator, result to accumulator
// - literal subtract: borrow and nibble borrow flags
// - file subtract: borrow and nibble borrow flags
// - file minus accumulator, destination bit selects
// - file minus accumulator minus inverted carry
// - swap file nibbles, flags untouched
// - sleep clears the power-down flag
// - sleep sets the time-out flag
// - sleep clears watchdog counter and prescaler
// - sleep halts the oscillator
`timescale 1ns/10ps
`include "sse_defines.svh"

module sse_exec
  import sse_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power and watchdog side
  input wire logic wake_event,
  input wire logic watchdog_timeout,
  output logic osc_halt,
  output logic watchdog_clear,
  output logic prescaler_clear
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // map a byte address to a register; misaligned or unknown gives none
  function automatic sse_reg_t reg_decode(input logic [7:0] a);
    sse_reg_t r;
    r = SSE_REG_NONE;
    case (a)
      `SSE_OFF_CMD: r = SSE_REG_CMD;
      `SSE_OFF_ACC: r = SSE_REG_ACC;
      `SSE_OFF_STATUS: r = SSE_REG_STATUS;
      `SSE_OFF_FADDR: r = SSE_REG_FADDR;
      `SSE_OFF_FDATA: r = SSE_REG_FDATA;
      `SSE_OFF_LAST: r = SSE_REG_LAST;
      default: r = SSE_REG_NONE;
    endcase
    return r;
  endfunction

  // merge write data into an old word under byte strobes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] file_mem [0:127];
  logic [7:0] acc;
  logic carry_flag;
  logic digit_carry_flag;
  logic zero_flag;
  logic timeout_flag_n;
  logic powerdown_flag_n;
  sse_pwr_t pwr;
  logic [31:0] cmd_q;
  logic [6:0] faddr_ptr;
  logic [7:0] last_result;
  sse_op_t last_op;

  // bus holding registers
  logic aw_held;
  logic [7:0] aw_addr_q;
  logic w_held;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  ////////////////////////////////////////////////////////////////////////////
  // write channel

  logic commit;
  sse_reg_t wr_idx;
  logic [31:0] next_cmd;
  logic [31:0] status_word;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign commit = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = reg_decode(aw_addr_q);

  // capture address and data independently, in either order
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (commit) begin
      aw_held <= 1'b0;
    end
  end

  // write data holding
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      w_held <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (commit) begin
      w_held <= 1'b0;
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSE_RESP_OKAY;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_idx == SSE_REG_NONE) ? `SSE_RESP_SLVERR : `SSE_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode and execution

  logic exec_go;
  sse_op_t cmd_op;
  logic [6:0] cmd_faddr;
  logic cmd_dest;
  logic [7:0] cmd_lit;
  logic sleep_go;
  logic [7:0] alu_result;
  logic alu_valid;
  logic alu_flags_we;
  logic alu_carry;
  logic alu_dc;
  logic alu_zero;

  // a command write runs the operation in the commit cycle; ignored while asleep
  assign next_cmd = wmerge(cmd_q, w_data_q, w_strb_q) & `SSE_CMD_MASK;
  assign exec_go = commit && (wr_idx == SSE_REG_CMD) && (w_strb_q != 4'h0) && (pwr == SSE_RUN);
  assign cmd_op = next_cmd[`SSE_CMD_OP_LSB +: 3];
  assign cmd_faddr = next_cmd[`SSE_CMD_FADDR_LSB +: 7];
  assign cmd_dest = next_cmd[`SSE_CMD_DEST_BIT];
  assign cmd_lit = next_cmd[`SSE_CMD_LIT_LSB +: 8];
  assign sleep_go = exec_go && (cmd_op == `SSE_OP_SLEEP);

  sse_alu u_alu (
    .op(cmd_op),
    .file_val(file_mem[cmd_faddr]),
    .acc_val(acc),
    .lit_val(cmd_lit),
    .carry_in(carry_flag),
    .result(alu_result),
    .result_valid(alu_valid),
    .flags_we(alu_flags_we),
    .carry_out(alu_carry),
    .dc_out(alu_dc),
    .zero_out(alu_zero)
  );

  // stored command word
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_q <= `SSE_CMD_RST;
    end else if (commit && wr_idx == SSE_REG_CMD) begin
      cmd_q <= next_cmd;
    end
  end

  // accumulator: literal subtract always lands here, others when destination is 0
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acc <= `SSE_ACC_RST;
    end else if (exec_go && alu_valid && (cmd_op == `SSE_OP_LIT || !cmd_dest)) begin
      acc <= alu_result;
    end else if (commit && wr_idx == SSE_REG_ACC && w_strb_q[0]) begin
      acc <= w_data_q[7:0];
    end
  end

  // file registers: result written back when destination is 1
  always_ff @(posedge ref_clk) begin
    if (exec_go && alu_valid && cmd_op != `SSE_OP_LIT && cmd_dest) begin
      file_mem[cmd_faddr] <= alu_result;
    end else if (commit && wr_idx == SSE_REG_FDATA && w_strb_q[0]) begin
      file_mem[faddr_ptr] <= w_data_q[7:0];
    end
  end

  // software pointer into the file registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      faddr_ptr <= `SSE_FADDR_RST;
    end else if (commit && wr_idx == SSE_REG_FADDR && w_strb_q[0]) begin
      faddr_ptr <= w_data_q[6:0];
    end
  end

  // arithmetic flags; swap and sleep leave them alone
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
    end else if (exec_go && alu_flags_we) begin
      carry_flag <= alu_carry;
      digit_carry_flag <= alu_dc;
      zero_flag <= alu_zero;
    end else if (commit && wr_idx == SSE_REG_STATUS && w_strb_q[0]) begin
      carry_flag <= w_data_q[`SSE_ST_C];
      digit_carry_flag <= w_data_q[`SSE_ST_DC];
      zero_flag <= w_data_q[`SSE_ST_Z];
    end
  end

  // power status flags, both high after reset; a watchdog time-out wins over sleep
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else begin
      if (watchdog_timeout) begin
        timeout_flag_n <= 1'b0;
      end else if (sleep_go) begin
        timeout_flag_n <= 1'b1;
      end
      if (sleep_go) begin
        powerdown_flag_n <= 1'b0;
      end
    end
  end

  // sleep state and oscillator halt, left by a wake event
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwr <= SSE_RUN;
      osc_halt <= 1'b0;
    end else begin
      case (pwr)
        SSE_RUN: begin
          if (sleep_go) begin
            pwr <= SSE_SLEEP;
            osc_halt <= 1'b1;
          end
        end
        SSE_SLEEP: begin
          if (wake_event) begin
            pwr <= SSE_RUN;
            osc_halt <= 1'b0;
          end
        end
        default: begin
          pwr <= SSE_RUN;
          osc_halt <= 1'b0;
        end
      endcase
    end
  end

  // one-cycle clear pulses for the watchdog counter and its prescaler
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      watchdog_clear <= 1'b0;
      prescaler_clear <= 1'b0;
    end else begin
      watchdog_clear <= sleep_go;
      prescaler_clear <= sleep_go;
    end
  end

  // last executed operation and its result
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      last_result <= 8'h00;
      last_op <= `SSE_OP_NONE;
    end else if (exec_go) begin
      last_result <= alu_result;
      last_op <= cmd_op;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  sse_reg_t rd_idx;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = reg_decode(s_axi_araddr);

  // status word as software sees it
  always_comb begin
    status_word = 32'h00000000;
    status_word[`SSE_ST_C] = carry_flag;
    status_word[`SSE_ST_DC] = digit_carry_flag;
    status_word[`SSE_ST_Z] = zero_flag;
    status_word[`SSE_ST_PD] = powerdown_flag_n;
    status_word[`SSE_ST_TO] = timeout_flag_n;
    status_word[`SSE_ST_SLEEP] = (pwr == SSE_SLEEP);
  end

  // read data registered one cycle after the address is taken
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SSE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SSE_RESP_OKAY;
      case (rd_idx)
        SSE_REG_CMD: s_axi_rdata <= cmd_q;
        SSE_REG_ACC: s_axi_rdata <= {24'h000000, acc};
        SSE_REG_STATUS: s_axi_rdata <= status_word;
        SSE_REG_FADDR: s_axi_rdata <= {25'h0000000, faddr_ptr};
        SSE_REG_FDATA: s_axi_rdata <= {24'h000000, file_mem[faddr_ptr]};
        SSE_REG_LAST: s_axi_rdata <= {13'h0000, last_op, 8'h00, last_result};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SSE_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### sse_exec_properties.sv
// checker for the sleep outputs and bus answers of the exec datapath
`timescale 1ns/10ps
`include "sse_defines.svh"

module sse_exec_properties
  import sse_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bus answers
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // power side
  input wire logic wake_event,
  input wire logic osc_halt,
  input wire logic watchdog_clear,
  input wire logic prescaler_clear
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////
  // sleep side effects
  clear_pulse_a: assert property (watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear longer than one cycle");
  clear_pair_a: assert property (watchdog_clear == prescaler_clear)
    else $error("prescaler clear differs from watchdog clear");
  halt_cause_a: assert property ($rose(osc_halt) |-> watchdog_clear)
    else $error("oscillator halted without a sleep");
  clear_halts_a: assert property (watchdog_clear |-> osc_halt)
    else $error("sleep did not halt the oscillator");
  halt_holds_a: assert property (osc_halt && !wake_event |=> osc_halt)
    else $error("sleep left without a wake event");
  wake_runs_a: assert property (osc_halt && wake_event |=> !osc_halt)
    else $error("wake event did not restart the oscillator");
  ////////////////////
  // bus answers
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped before taken");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  // main scenarios
  cover property ($rose(osc_halt));
  cover property (osc_halt && wake_event);
  cover property (s_axi_rvalid && s_axi_rresp == `SSE_RESP_SLVERR);
endmodule

bind sse_exec sse_exec_properties chk (.ref_clk, .reset, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .wake_event, .osc_halt, .watchdog_clear, .prescaler_clear);

// ### subtract_swap_sleep_exec_test.sv
// self-checking bench for the subtract, swap and sleep datapath
`timescale 1ns/10ps
`include "sse_defines.svh"

module subtract_swap_sleep_exec_test
  import sse_pkg::*;
;
  typedef struct packed {logic [2:0] op; logic d; logic [2:0] st;
    logic [7:0] k; logic [7:0] f; logic [7:0] w;} sse_row_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, wake_event = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic osc_halt, watchdog_clear, prescaler_clear;
  logic [10:0] ex;
  logic [6:0] a;
  sse_row_t rw;
  int err_total = 0, compares = 0, clr_cnt = 0, n;
  // op, dest, status in, literal, file, acc
  sse_row_t rows[11] = '{'{3'h1, 1'b0, 3'h0, 8'h05, 8'h00, 8'h05},
    '{3'h1, 1'b1, 3'h7, 8'h10, 8'h00, 8'h01}, '{3'h1, 1'b0, 3'h0, 8'h03, 8'h00, 8'h04},
    '{3'h1, 1'b0, 3'h0, 8'hFF, 8'h00, 8'h00}, '{3'h2, 1'b0, 3'h0, 8'h00, 8'h80, 8'h7F},
    '{3'h2, 1'b1, 3'h7, 8'h00, 8'h12, 8'h34}, '{3'h3, 1'b0, 3'h0, 8'h00, 8'h10, 8'h0F},
    '{3'h3, 1'b1, 3'h1, 8'h00, 8'h00, 8'h00}, '{3'h3, 1'b0, 3'h4, 8'h00, 8'h00, 8'h00},
    '{3'h4, 1'b0, 3'h5, 8'h00, 8'hA5, 8'h11}, '{3'h4, 1'b1, 3'h2, 8'h00, 8'h3C, 8'h99}};

  sse_exec DUT (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wake_event, .watchdog_timeout,
    .osc_halt, .watchdog_clear, .prescaler_clear);

  // clock and count of clear pulses
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (watchdog_clear && prescaler_clear) clr_cnt++;
  end
  ////////////////////
  task automatic stop_test();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input logic ok);
    if (!ok) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic bus_write(input logic [7:0] ad, input logic [31:0] wd);
    logic pa, pw, hit;
    pa = 1'b1; pw = 1'b1; hit = 1'b0; n = 0;
    s_axi_awaddr <= ad; s_axi_wdata <= wd; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    while ((pa || pw) && n < 40) begin
      #1; if (s_axi_awready) pa = 1'b0; if (s_axi_wready) pw = 1'b0;
      @(posedge ref_clk); n++;
      if (!pa) s_axi_awvalid <= 1'b0; if (!pw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    while (!hit && n < 80) begin
      #1; hit = s_axi_bvalid; r = s_axi_bresp;
      @(posedge ref_clk); n++;
    end
    s_axi_bready <= 1'b0;
    tmo(hit);
  endtask
  task automatic bus_read(input logic [7:0] ad);
    logic hit;
    hit = 1'b0; n = 0;
    s_axi_araddr <= ad; s_axi_arvalid <= 1'b1;
    while (!hit && n < 40) begin
      #1; hit = s_axi_arready; @(posedge ref_clk); n++;
    end
    s_axi_arvalid <= 1'b0; s_axi_rready <= 1'b1; hit = 1'b0;
    while (!hit && n < 80) begin
      #1; hit = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp;
      @(posedge ref_clk); n++;
    end
    s_axi_rready <= 1'b0;
    tmo(hit);
  endtask
  // expected flags {z,dc,c} and result, from operand comparisons
  function automatic logic [10:0] expect_of(input sse_row_t x);
    logic [7:0] m, q;
    logic b;
    m = (x.op == `SSE_OP_LIT) ? x.k : x.f;
    b = (x.op == `SSE_OP_BORROW) ? !x.st[0] : 1'b0;
    q = m - x.w - {7'h00, b};
    if (x.op == `SSE_OP_SWAP) return {x.st, x.f[3:0], x.f[7:4]};
    return {q == 8'h00, {1'b0, m[3:0]} >= {1'b0, x.w[3:0]} + {4'h0, b},
      {1'b0, m} >= {1'b0, x.w} + {8'h00, b}, q};
  endfunction
  ////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    bus_read(`SSE_OFF_STATUS); check(d, 32'h18);
    bus_read(`SSE_OFF_ACC); check(d, 32'h0);
    for (int i = 0; i < 11; i++) begin
      rw = rows[i]; ex = expect_of(rw); a = 7'h7F - 7'(i);
      bus_write(`SSE_OFF_ACC, {24'h0, rw.w});
      bus_write(`SSE_OFF_FADDR, {25'h0, a});
      bus_write(`SSE_OFF_FDATA, {24'h0, rw.f});
      bus_write(`SSE_OFF_STATUS, {29'h0, rw.st});
      bus_write(`SSE_OFF_CMD, {13'h0, rw.op, rw.d, a, rw.k});
      check(r, `SSE_RESP_OKAY);
      bus_read(`SSE_OFF_ACC);
      check(d, {24'h0, (rw.op == 3'h1 || !rw.d) ? ex[7:0] : rw.w});
      bus_read(`SSE_OFF_FDATA);
      check(d, {24'h0, (rw.op != 3'h1 && rw.d) ? ex[7:0] : rw.f});
      bus_read(`SSE_OFF_STATUS);
      check(d, {27'h0, 2'h3, ex[10:8]});
    end
    // last operation register after the table, then a code that leaves accumulator, file and flags alone
    bus_read(`SSE_OFF_LAST); check(d, 32'h000400C3);
    bus_write(`SSE_OFF_CMD, {13'h0, 3'h6, 16'h0});
    bus_read(`SSE_OFF_ACC); check(d, 32'h99);
    bus_read(`SSE_OFF_STATUS); check(d, 32'h1A);
    // unmapped place: data and response checked apart, no bits dropped
    bus_read(8'h40);
    check(d, 32'h0);
    check(r, `SSE_RESP_SLVERR);
    bus_write(8'h40, 32'h5); check(r, `SSE_RESP_SLVERR);
    // time-out flag low first, so sleep must raise it
    watchdog_timeout <= 1'b1;
    @(posedge ref_clk);
    watchdog_timeout <= 1'b0;
    bus_read(`SSE_OFF_STATUS); check(d, 32'h0A);
    bus_write(`SSE_OFF_CMD, {13'h0, `SSE_OP_SLEEP, 16'h0});
    check(osc_halt, 1'b1);
    // let the pulse counter settle before it is read
    @(posedge ref_clk);
    check(clr_cnt, 1);
    bus_read(`SSE_OFF_STATUS); check(d, 32'h32);
    bus_write(`SSE_OFF_CMD, {13'h0, `SSE_OP_LIT, 16'h0077});
    bus_read(`SSE_OFF_ACC); check(d, 32'h99);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    @(posedge ref_clk);
    check(osc_halt, 1'b0);
    bus_read(`SSE_OFF_STATUS); check(d, 32'h12);
    // a second sleep, then a reset in mid-run while asleep
    bus_write(`SSE_OFF_CMD, {13'h0, `SSE_OP_SLEEP, 16'h0});
    check(osc_halt, 1'b1);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    check(osc_halt, 1'b0);
    check(clr_cnt, 2);
    bus_read(`SSE_OFF_STATUS); check(d, 32'h18);
    bus_read(`SSE_OFF_ACC); check(d, 32'h0);
    bus_read(`SSE_OFF_LAST); check(d, 32'h0);
    stop_test();
  end
endmodule
